// ---- hw/cfg_pkg.sv ----
// Purpose: shared constants for the configuration word decoder
// Assumes: 24-bit configuration words, 16-bit register port
// Notes: offsets of the register port are local choices
package cfg_pkg;
    // ************
    // register map
    // ************
    localparam logic [3:0] OFF_PROT_POWER = 4'h0;
    localparam logic [3:0] OFF_DEEP_SLEEP = 4'h1;
    localparam logic [3:0] OFF_PART_ID = 4'h2;
    localparam logic [3:0] OFF_REVISION = 4'h3;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_FLAG_CLEAR = 4'h5;
    localparam logic [3:0] OFF_BOUNDS_LO = 4'h6;
    localparam logic [3:0] OFF_BOUNDS_HI = 4'h7;
    // ************
    // protection and power word fields
    // ************
    localparam int POS_SEG_END = 15;
    localparam int POS_CFG_PAGE = 14;
    localparam int POS_SEG_DIS = 13;
    localparam int POS_WAKE = 10;
    localparam int POS_SECONDARY_OSCILLATOR = 8;
    localparam int POS_PAGE = 0;
    localparam logic [23:0] PROT_IMPL_MASK = 24'h00EF3F;
    // ************
    // deep sleep word fields
    // ************
    localparam int POS_DSW_EN = 7;
    localparam int POS_DS_BOR = 6;
    localparam int POS_RTC_SEL = 5;
    localparam int POS_DSW_CLK = 4;
    localparam int POS_DSW_PS = 0;
    localparam logic [23:0] DEEP_IMPL_MASK = 24'h0000FF;
    localparam logic [23:0] UNPROG_WORD = 24'hFFFFFF;
    // ************
    // codes and sizes
    // ************
    localparam logic [1:0] WAKE_DEFAULT = 2'h3;
    localparam logic [1:0] WAKE_FAST = 2'h1;
    localparam logic [1:0] SECONDARY_OSCILLATOR_HIGH = 2'h3;
    localparam logic [1:0] SECONDARY_OSCILLATOR_LOW = 2'h1;
    localparam logic [1:0] SECONDARY_OSCILLATOR_DIGITAL = 2'h0;
    localparam int PAGE_SHIFT = 9; // 512 instructions per page
    localparam logic [5:0] LAST_PAGE = 6'h3F;
    localparam int DSW_PRESCALE = 32;
    // ************
    // identity, arbitrary neutral values
    // ************
    localparam logic [7:0] FAMILY_ID = 8'hA5;
    localparam logic [7:0] DEVICE_ID = 8'h5A;
    localparam logic [3:0] REVISION_ID = 4'h1;
    // ************
    // timing
    // ************
    localparam int CLK_MHZ = 20;
    localparam int WAKE_DEFAULT_US = 190;
    localparam int WAKE_FAST_US = 10;
    localparam int WAKE_DEFAULT_CYC = WAKE_DEFAULT_US * CLK_MHZ;
    localparam int WAKE_FAST_CYC = WAKE_FAST_US * CLK_MHZ;
    localparam int SYNC_STAGES = 3;
endpackage : cfg_pkg

// ---- hw/pin_sync.sv ----
// Purpose: three-stage synchroniser for an asynchronous level
// Assumes: single clock mclk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module pin_sync (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage;

    // shift chain; first stage feeds only the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], async_in};
        end
    end

    // hold last agreed value to filter a one-cycle disagreement
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync_out <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            sync_out <= stage[2];
        end
    end
endmodule : pin_sync

// ---- hw/wake_timer.sv ----
// Purpose: regulator standby wake-up delay counter
// Assumes: start is a one-cycle pulse, code held constant
// Notes: reserved codes fall back to the default delay
`timescale 1ns/1ps
module wake_timer (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [1:0] wake_code,
    output logic busy,
    output logic done
);
    logic [12:0] count;

    // load on start, count down, pulse done at zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count <= 13'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                if (wake_code == cfg_pkg::WAKE_FAST) begin
                    count <= 13'(cfg_pkg::WAKE_FAST_CYC - 1);
                end else begin
                    count <= 13'(cfg_pkg::WAKE_DEFAULT_CYC - 1);
                end
            end else if (busy) begin
                if (count == 13'h0000) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 13'h0001;
                end
            end
        end
    end
endmodule : wake_timer

// ---- hw/config_word_decoder.sv ----
// Purpose: decode the nonvolatile configuration words for on-chip logic
// Assumes: words presented from flash and stable while load_done rises
// Notes: registers are read-only except the flag clear location
`timescale 1ns/1ps
module config_word_decoder (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [23:0] prot_word_in,
    input wire logic [23:0] deep_word_in,
    input wire logic load_done,
    input wire logic regulator_disable_strap,
    input wire logic supply_low_in,
    input wire logic standby_wake,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic config_valid,
    output logic segment_protect_on,
    output logic [15:0] segment_low_addr,
    output logic [15:0] segment_high_addr,
    output logic config_page_protected,
    output logic [1:0] regulator_wake_select,
    output logic wake_select_reserved,
    output logic wake_busy,
    output logic wake_done,
    output logic secondary_oscillator_high_drive,
    output logic secondary_oscillator_low_drive,
    output logic secondary_oscillator_digital_io,
    output logic secondary_oscillator_mode_reserved,
    output logic deep_sleep_watchdog_enable,
    output logic deep_sleep_brownout_enable,
    output logic rtc_from_secondary_osc,
    output logic dsw_from_low_power_rc,
    output logic [5:0] dsw_prescale_log2,
    output logic [5:0] dsw_postscale_log2,
    output logic low_voltage_flag
);
    // ************
    // latched configuration
    // ************
    logic [23:0] protection_and_power_config;
    logic [23:0] deep_sleep_config;
    logic load_seen;
    logic regulator_enabled;
    logic supply_low_sync;
    logic strap_sync;
    logic [15:0] page_base;
    logic [15:0] page_top;
    logic [5:0] page;
    logic [1:0] secondary_oscillator_code;
    logic [3:0] ps_code;
    logic [15:0] next_segment_low;
    logic [15:0] next_segment_high;
    logic [5:0] next_postscale_log2;

    // decode of a two-bit oscillator power code, used for flags and status
    function automatic logic [3:0] secondary_oscillator_decode(input logic [1:0] code);
        secondary_oscillator_decode = {code == cfg_pkg::SECONDARY_OSCILLATOR_HIGH, code == cfg_pkg::SECONDARY_OSCILLATOR_LOW,
                       code == cfg_pkg::SECONDARY_OSCILLATOR_DIGITAL, code == 2'h2};
    endfunction : secondary_oscillator_decode

    // strap and supply comparator are pins from outside the clock
    pin_sync u_strap_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(regulator_disable_strap),
        .sync_out(strap_sync)
    );

    pin_sync u_supply_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(supply_low_in),
        .sync_out(supply_low_sync)
    );

    // capture once after reset release; later loads are ignored
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            protection_and_power_config <= cfg_pkg::UNPROG_WORD;
            deep_sleep_config <= cfg_pkg::UNPROG_WORD;
            load_seen <= 1'b0;
        end else if (load_done && !load_seen) begin
            load_seen <= 1'b1;
            protection_and_power_config <= prot_word_in | ~cfg_pkg::PROT_IMPL_MASK;
            deep_sleep_config <= deep_word_in | ~cfg_pkg::DEEP_IMPL_MASK;
        end
    end

    // regulator state taken from the strap as the load completes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regulator_enabled <= 1'b0;
        end else if (load_done && !load_seen) begin
            regulator_enabled <= !strap_sync;
        end
    end

    assign config_valid = load_seen;

    // ************
    // write protection segment
    // ************
    assign page = protection_and_power_config[cfg_pkg::POS_PAGE +: 6];
    assign page_base = {page, 10'h000} >> 1;
    assign page_top = page_base + 16'(1 << cfg_pkg::PAGE_SHIFT) - 16'h0001;

    // bounds selected by end select
    always_comb begin
        next_segment_low = 16'h0000;
        next_segment_high = 16'h0000;
        if (protection_and_power_config[cfg_pkg::POS_SEG_END]) begin
            next_segment_low = 16'h0000;
            next_segment_high = page_top;
        end else begin
            next_segment_low = page_base;
            next_segment_high = {cfg_pkg::LAST_PAGE, 10'h3FF} >> 1;
        end
    end

    // address outputs from flops; one cycle behind capture, harmless as words freeze
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            segment_low_addr <= 16'h0000;
            segment_high_addr <= 16'h0000;
        end else begin
            segment_low_addr <= next_segment_low;
            segment_high_addr <= next_segment_high;
        end
    end

    assign segment_protect_on = load_seen &&
        !protection_and_power_config[cfg_pkg::POS_SEG_DIS];
    assign config_page_protected = load_seen &&
        !protection_and_power_config[cfg_pkg::POS_CFG_PAGE];

    // ************
    // regulator wake and secondary oscillator
    // ************
    assign regulator_wake_select = protection_and_power_config[cfg_pkg::POS_WAKE +: 2];
    assign wake_select_reserved = !regulator_wake_select[0];

    wake_timer u_wake (
        .mclk(mclk),
        .resetn(resetn),
        .start(standby_wake && regulator_enabled),
        .wake_code(regulator_wake_select),
        .busy(wake_busy),
        .done(wake_done)
    );

    assign secondary_oscillator_code = protection_and_power_config[cfg_pkg::POS_SECONDARY_OSCILLATOR +: 2];
    // drive modes from one decode; reserved code enables nothing
    assign {secondary_oscillator_high_drive, secondary_oscillator_low_drive, secondary_oscillator_digital_io, secondary_oscillator_mode_reserved} =
        secondary_oscillator_decode(secondary_oscillator_code);

    // ************
    // deep sleep options
    // ************
    assign deep_sleep_watchdog_enable = deep_sleep_config[cfg_pkg::POS_DSW_EN];
    assign deep_sleep_brownout_enable = deep_sleep_config[cfg_pkg::POS_DS_BOR];
    assign rtc_from_secondary_osc = deep_sleep_config[cfg_pkg::POS_RTC_SEL];
    assign dsw_from_low_power_rc = deep_sleep_config[cfg_pkg::POS_DSW_CLK];
    assign ps_code = deep_sleep_config[cfg_pkg::POS_DSW_PS +: 4];
    assign next_postscale_log2 = {1'b0, ps_code, 1'b1};

    // scaling exponents held in flops; prescale fixed, postscale 2n+1
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dsw_prescale_log2 <= 6'h00;
            dsw_postscale_log2 <= 6'h00;
        end else begin
            dsw_prescale_log2 <= 6'($clog2(cfg_pkg::DSW_PRESCALE));
            dsw_postscale_log2 <= next_postscale_log2;
        end
    end

    // ************
    // low-voltage flag
    // ************
    // set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            low_voltage_flag <= 1'b0;
        end else if (regulator_enabled && supply_low_sync) begin
            low_voltage_flag <= 1'b1;
        end else if (reg_write && reg_addr == cfg_pkg::OFF_FLAG_CLEAR && reg_wdata[0]) begin
            low_voltage_flag <= 1'b0;
        end
    end

    // ************
    // register read port
    // ************
    // unmapped addresses read zero; data stand one cycle after the strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                cfg_pkg::OFF_PROT_POWER: reg_rdata <= protection_and_power_config[15:0];
                cfg_pkg::OFF_DEEP_SLEEP: reg_rdata <= deep_sleep_config[15:0];
                cfg_pkg::OFF_PART_ID: reg_rdata <=
                    {cfg_pkg::FAMILY_ID, cfg_pkg::DEVICE_ID};
                cfg_pkg::OFF_REVISION: reg_rdata <= {12'h000, cfg_pkg::REVISION_ID};
                cfg_pkg::OFF_STATUS: reg_rdata <= {10'h000, secondary_oscillator_high_drive, secondary_oscillator_low_drive,
                    wake_busy, regulator_enabled, low_voltage_flag, load_seen};
                cfg_pkg::OFF_BOUNDS_LO: reg_rdata <= segment_low_addr;
                cfg_pkg::OFF_BOUNDS_HI: reg_rdata <= segment_high_addr;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : config_word_decoder

// ---- bench/config_word_decoder_asserts.sv ----
// Purpose: port checks for config_word_decoder
// Assumes: one clock mclk, async active-low resetn
// Notes: bound from the bench top file
`timescale 1ns/1ps
module config_word_decoder_asserts (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [15:0] reg_rdata,
    input wire logic config_valid,
    input wire logic secondary_oscillator_high_drive,
    input wire logic secondary_oscillator_low_drive,
    input wire logic secondary_oscillator_digital_io,
    input wire logic secondary_oscillator_mode_reserved,
    input wire logic [1:0] regulator_wake_select,
    input wire logic wake_select_reserved,
    input wire logic wake_busy,
    input wire logic wake_done,
    input wire logic low_voltage_flag
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_id_read;
        reg_read && reg_addr == cfg_pkg::OFF_PART_ID
            |=> reg_rdata == {cfg_pkg::FAMILY_ID, cfg_pkg::DEVICE_ID};
    endproperty
    a_id_read: assert property (p_id_read) else $error("id read wrong");
    property p_rev_read;
        reg_read && reg_addr == cfg_pkg::OFF_REVISION
            |=> reg_rdata == {12'h000, cfg_pkg::REVISION_ID};
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision read wrong");
    property p_unused_ones;
        reg_read && reg_addr == cfg_pkg::OFF_DEEP_SLEEP |=> reg_rdata[15:8] == 8'hFF;
    endproperty
    a_unused_ones: assert property (p_unused_ones) else $error("unused bits not one");
    property p_secondary_oscillator_onehot;
        $onehot({secondary_oscillator_high_drive, secondary_oscillator_low_drive, secondary_oscillator_digital_io, secondary_oscillator_mode_reserved});
    endproperty
    a_secondary_oscillator_onehot: assert property (p_secondary_oscillator_onehot) else $error("osc mode not one-hot");
    property p_wake_res;
        wake_select_reserved == (regulator_wake_select != cfg_pkg::WAKE_DEFAULT &&
            regulator_wake_select != cfg_pkg::WAKE_FAST);
    endproperty
    a_wake_res: assert property (p_wake_res) else $error("reserved wake code");
    // fields must not move once captured, even if flash inputs wander
    property p_frozen;
        config_valid |=> config_valid && $stable({regulator_wake_select, secondary_oscillator_digital_io});
    endproperty
    a_frozen: assert property (p_frozen) else $error("config changed");
    property p_wake_fast;
        $rose(wake_busy) && regulator_wake_select == cfg_pkg::WAKE_FAST
            |-> ##[190:210] wake_done;
    endproperty
    a_wake_fast: assert property (p_wake_fast) else $error("fast wake late");
    property p_flag_sticky;
        low_voltage_flag && !reg_write |=> low_voltage_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
endmodule : config_word_decoder_asserts

// ---- bench/config_word_decoder_test.sv ----
// Purpose: self-checking bench for config_word_decoder
// Assumes: 20 MHz mclk, read data one cycle after the strobe
// Notes: each row reloads the words through a fresh reset
`timescale 1ns/1ps
module config_word_decoder_test;
    logic mclk = 1'b0, resetn = 1'b0, load_done = 1'b0, strap = 1'b0;
    logic supply_low = 1'b0, standby_wake = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [23:0] prot_in = 24'h000000, deep_in = 24'h000000;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, lo, hi, rd;
    logic config_valid, prot_on, cfg_prot, wsel_res, busy, done, dig, high, low, res;
    logic dsw_en, bor_en, rtc_secondary_oscillator, dsw_low_power_rc_oscillator, flag;
    logic [1:0] wsel;
    logic [5:0] pre, post;
    int num_errors = 0, num_checks = 0, cycles = 0, n;
    typedef struct packed {
        logic [15:0] prot;
        logic [7:0] deep;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [3:0] secondary_oscillator;
    } row_t;
    // words in, then bounds and {high, low, digital, reserved}
    row_t rows [4] = '{'{16'h8E05, 8'h00, 16'h0000, 16'h0BFF, 4'h1},
        '{16'h4500, 8'hA7, 16'h0000, 16'h7FFF, 4'h4},
        '{16'h2C3F, 8'h5F, 16'h7E00, 16'h7FFF, 4'h2},
        '{16'hE3FF, 8'hF3, 16'h0000, 16'h7FFF, 4'h8}};
    config_word_decoder DUT (.mclk(mclk), .resetn(resetn), .prot_word_in(prot_in),
        .deep_word_in(deep_in), .load_done(load_done), .regulator_disable_strap(strap),
        .supply_low_in(supply_low), .standby_wake(standby_wake), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .config_valid(config_valid), .segment_protect_on(prot_on),
        .segment_low_addr(lo), .segment_high_addr(hi), .config_page_protected(cfg_prot),
        .regulator_wake_select(wsel), .wake_select_reserved(wsel_res), .wake_busy(busy),
        .wake_done(done), .secondary_oscillator_high_drive(high), .secondary_oscillator_low_drive(low),
        .secondary_oscillator_digital_io(dig), .secondary_oscillator_mode_reserved(res), .deep_sleep_watchdog_enable(dsw_en),
        .deep_sleep_brownout_enable(bor_en), .rtc_from_secondary_osc(rtc_secondary_oscillator),
        .dsw_from_low_power_rc(dsw_low_power_rc_oscillator), .dsw_prescale_log2(pre),
        .dsw_postscale_log2(post), .low_voltage_flag(flag));
    always #25 mclk = ~mclk;
    // hang guard, well above the longest wake delay
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic rd_reg(input logic [3:0] a);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk) rd = reg_rdata;
        @(posedge mclk);
    endtask : rd_reg
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
        @(posedge mclk);
    endtask : wr_reg
    // strap goes through a synchroniser, so wait before capture
    task automatic load(input logic [15:0] p, input logic [7:0] d, input logic s);
        resetn <= 1'b0;
        prot_in <= {8'h00, p};
        deep_in <= {16'h0000, d};
        strap <= s;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        repeat (6) @(posedge mclk);
        load_done <= 1'b1;
        @(posedge mclk);
        load_done <= 1'b0;
        @(posedge mclk);
    endtask : load
    task automatic wake(input int lo_n, input int hi_n);
        standby_wake <= 1'b1;
        @(posedge mclk);
        standby_wake <= 1'b0;
        for (n = 0; n < 4000 && done !== 1'b1; n++) @(negedge mclk);
        chk_val({15'h0000, n > lo_n && n < hi_n}, 16'h0001);
        @(posedge mclk);
    endtask : wake
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        @(negedge mclk);
        chk_val({12'h000, config_valid, flag, busy, |reg_rdata}, 16'h0000);
        @(posedge mclk);
        foreach (rows[i]) begin
            load(rows[i].prot, rows[i].deep, 1'b0);
            @(negedge mclk);
            chk_val(lo, rows[i].lo);
            chk_val(hi, rows[i].hi);
            chk_val({prot_on, cfg_prot, wsel, wsel_res, 11'h000}, {~rows[i].prot[13],
                ~rows[i].prot[14], rows[i].prot[11:10], ~rows[i].prot[10], 11'h000});
            chk_val({12'h000, dsw_en, bor_en, rtc_secondary_oscillator, dsw_low_power_rc_oscillator},
                {12'h000, rows[i].deep[7:4]});
            chk_val({high, low, dig, res, post, pre},
                {rows[i].secondary_oscillator, 1'b0, rows[i].deep[3:0], 1'b1, 6'h05});
            @(posedge mclk);
            rd_reg(cfg_pkg::OFF_PROT_POWER);
            chk_val(rd, rows[i].prot | 16'h10C0);
            rd_reg(cfg_pkg::OFF_DEEP_SLEEP);
            chk_val(rd, {8'hFF, rows[i].deep});
            rd_reg(cfg_pkg::OFF_BOUNDS_LO);
            chk_val(rd, rows[i].lo);
            rd_reg(cfg_pkg::OFF_BOUNDS_HI);
            chk_val(rd, rows[i].hi);
            $display("row %0d done", i);
        end
        // writes and a late load strobe must leave everything as captured
        wr_reg(cfg_pkg::OFF_PROT_POWER, 16'h0000);
        wr_reg(cfg_pkg::OFF_PART_ID, 16'h0000);
        prot_in <= 24'h000000;
        load_done <= 1'b1;
        @(posedge mclk);
        load_done <= 1'b0;
        rd_reg(cfg_pkg::OFF_PROT_POWER);
        chk_val(rd, 16'hF3FF);
        rd_reg(cfg_pkg::OFF_PART_ID);
        chk_val(rd, {cfg_pkg::FAMILY_ID, cfg_pkg::DEVICE_ID});
        rd_reg(cfg_pkg::OFF_REVISION);
        chk_val(rd, {12'h000, cfg_pkg::REVISION_ID});
        rd_reg(4'hF);
        chk_val(rd, 16'h0000);
        $display("register test done");
        // low supply with regulator on: flag sets, sticks, clears
        load(16'h4500, 8'h00, 1'b0);
        supply_low <= 1'b1;
        for (n = 0; n < 10 && flag !== 1'b1; n++) @(negedge mclk);
        chk_val({15'h0000, flag}, 16'h0001);
        @(posedge mclk);
        supply_low <= 1'b0;
        repeat (8) @(posedge mclk);
        chk_val({15'h0000, flag}, 16'h0001);
        rd_reg(cfg_pkg::OFF_STATUS);
        chk_val(rd, 16'h0017);
        wr_reg(cfg_pkg::OFF_FLAG_CLEAR, 16'h0001);
        @(negedge mclk);
        chk_val({15'h0000, flag}, 16'h0000);
        @(posedge mclk);
        wake(190, 210);
        load(16'h8E05, 8'h00, 1'b0);
        wake(3790, 3810);
        $display("flag and wake test done");
        // regulator strapped off: no detection at all
        load(16'h8E05, 8'h00, 1'b1);
        supply_low <= 1'b1;
        repeat (20) @(negedge mclk);
        chk_val({15'h0000, flag}, 16'h0000);
        $display("regulator off test done");
        finish_test();
    end
endmodule : config_word_decoder_test
bind config_word_decoder config_word_decoder_asserts chk (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write), .reg_rdata(reg_rdata),
    .config_valid(config_valid), .secondary_oscillator_high_drive(secondary_oscillator_high_drive),
    .secondary_oscillator_low_drive(secondary_oscillator_low_drive), .secondary_oscillator_digital_io(secondary_oscillator_digital_io),
    .secondary_oscillator_mode_reserved(secondary_oscillator_mode_reserved), .regulator_wake_select(regulator_wake_select),
    .wake_select_reserved(wake_select_reserved), .wake_busy(wake_busy),
    .wake_done(wake_done), .low_voltage_flag(low_voltage_flag));
